// *** pkg/halt_pkg.sv ***
// Purpose: Shared constants and carrier types for the thread halt/sleep control block.
// Assumes: Two hardware threads per core, core clock 100 MHz.
// Notes:   Instruction fields follow the format-3 layout.
`default_nettype none
package halt_pkg;
  // ==========================================================================
  // Instruction decode
  localparam logic [1:0]  OP_FMT3      = 2'h2;
  localparam logic [5:0]  OP3_IMPDEP   = 6'h36;
  localparam logic [8:0]  OPF_SUSPEND  = 9'h082;
  localparam logic [8:0]  OPF_SLEEP    = 9'h083;
  localparam int          OP_HI        = 31;
  localparam int          OP_LO        = 30;
  localparam int          OP3_HI       = 24;
  localparam int          OP3_LO       = 19;
  localparam int          OPF_HI       = 13;
  localparam int          OPF_LO       = 5;

  // ==========================================================================
  // Timing
  localparam int          CLK_MHZ       = 100;
  localparam int          SLEEP_TIMEOUT_NS = 1600;
  localparam int          SLEEP_CYCLES  = (SLEEP_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int          TMR_W         = 12;
  localparam logic [TMR_W-1:0] TMR_RESET = 12'h000;

  // ==========================================================================
  // Threads and busy flags
  localparam int          NTHR          = 2;
  localparam int          NFLAG         = 8;

  typedef enum logic [1:0] {RUN, HALTED, ASLEEP} thr_state_e;

  typedef enum logic [2:0] {WAKE_NONE, WAKE_TIMEOUT, WAKE_FLAG, WAKE_SIBLING, WAKE_INTR} wake_cause_e;

  // Per-thread event inputs from interrupt and reset logic
  typedef struct packed {
    logic vec_intr;
    logic lvl_intr;
    logic sys_reset;
  } thr_evt_s;

  // Issue request for one thread
  typedef struct packed {
    logic        valid;
    logic [31:0] insn;
    logic        priv;
    logic        global_interrupt_enable;
  } issue_s;

  // Per-thread outcome
  typedef struct packed {
    logic        halted;
    logic        force_ie;
    logic        priv_trap;
    logic        resume;
    logic        take_trap;
    wake_cause_e cause;
  } thr_out_s;

endpackage : halt_pkg
`default_nettype wire

// *** rtl/sleep_timer.sv ***
// Purpose: Per-thread sleep timeout counter.
// Assumes: Ticks on the core clock, same clock as the system tick counter.
// Notes:   Expires once after SLEEP_CYCLES cycles of run.
`default_nettype none
module sleep_timer
  import halt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic run,
  output logic      expired
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             exp;
  } tmr_s;

  tmr_s st_r;
  tmr_s st_nxt;

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.exp = 1'b0;
    if (start)
      st_nxt.cnt = TMR_RESET;
    else if (run)
    begin
      st_nxt.cnt = st_r.cnt + 12'h001;
      // Counted on the core clock, no separate time base [RQ7]
      if (st_r.cnt == TMR_W'(SLEEP_CYCLES - 1))
        st_nxt.exp = 1'b1; // [RQ6]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign expired = st_r.exp;
endmodule : sleep_timer
`default_nettype wire

// *** rtl/busy_watch.sv ***
// Purpose: Per-thread busy-flag update watcher with a pending memory.
// Assumes: One update strobe per flag per cycle, assignment mask is stable.
// Notes:   Only flags assigned to the thread's busy-flag spaces count.
`default_nettype none
module busy_watch
  import halt_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [NFLAG-1:0] assigned,
  input  wire logic [NFLAG-1:0] update,
  input  wire logic             consume,
  output logic                  hit,
  output logic                  pending
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic hit;
    logic pend;
  } bw_s;

  bw_s st_r;
  bw_s st_nxt;
  logic any_upd;

  always_comb
  begin
    any_upd = |(update & assigned); // [RQ8]
    st_nxt.hit = any_upd;
    // New update wins over a simultaneous consume [RQ10]
    st_nxt.pend = any_upd | (st_r.pend & ~consume);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign hit     = st_r.hit;
  assign pending = st_r.pend;
endmodule : busy_watch
`default_nettype wire

// *** rtl/thread_halt_ctrl.sv ***
// Purpose: Suspend and sleep control for the two hardware threads of a core.
// Assumes: Events arrive on sys_clk from same-domain logic; one issue per thread per cycle.
// Notes:   All outputs are registered.
`default_nettype none
// ============================================================================
// Notes on behaviour
// [RQ1] Opcode space 110110 with function 0 1000 0010 is suspend; thread halts.
// [RQ2] Suspend forces the thread's global interrupt enable to one.
// [RQ3] Halted thread leaves only on reset, vectored or level interrupt trap.
// [RQ4] Function 0 1000 0011 in the same space is sleep; thread sleeps.
// [RQ5] Sleeping thread wakes on reset, vectored or level interrupt trap.
// [RQ6] Sleeping thread wakes itself about 1.6 microseconds after entry.
// [RQ7] Timeout counts on the core clock that drives the system tick counter.
// [RQ8] Update of an assigned busy flag wakes; unassigned flags do not.
// [RQ9] Sleep entered with interrupts disabled ignores vectored interrupts.
// [RQ10] Busy-flag update while awake makes the next sleep complete at once.
// [RQ11] Sleep while sibling sleeps puts this thread asleep and wakes sibling.
// [RQ12] Suspend outside privileged mode traps; sleep never raises an exception.
// [RQ13] Timeout or flag wake resumes next instruction; interrupt wake takes trap.
module thread_halt_ctrl
  import halt_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire issue_s   [NTHR-1:0]         issue,
  input  wire thr_evt_s [NTHR-1:0]         evt,
  input  wire logic     [NTHR-1:0][NFLAG-1:0] flag_assigned,
  input  wire logic     [NFLAG-1:0]        flag_update,
  output thr_out_s      [NTHR-1:0]         thr_out
);
  // ==========================================================================
  // Decode
  function automatic logic is_op(input logic [31:0] insn, input logic [8:0] opf);
    is_op = (insn[OP_HI:OP_LO] == OP_FMT3) && (insn[OP3_HI:OP3_LO] == OP3_IMPDEP)
            && (insn[OPF_HI:OPF_LO] == opf);
  endfunction : is_op

  // ==========================================================================
  // State
  typedef struct packed {
    thr_state_e [NTHR-1:0] st;
    logic       [NTHR-1:0] ie_at_sleep;
    thr_out_s   [NTHR-1:0] out;
  } ctl_s;

  ctl_s ctl_r;
  ctl_s ctl_nxt;

  logic [NTHR-1:0] tmr_start;
  logic [NTHR-1:0] tmr_run;
  logic [NTHR-1:0] tmr_exp;
  logic [NTHR-1:0] bw_hit;
  logic [NTHR-1:0] bw_pend;
  logic [NTHR-1:0] bw_consume;
  logic [NTHR-1:0] do_susp;
  logic [NTHR-1:0] do_sleep;

  for (genvar t = 0; t < NTHR; t++)
  begin : g_thr
    sleep_timer u_tmr (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .start   (tmr_start[t]),
      .run     (tmr_run[t]),
      .expired (tmr_exp[t])
    );
    busy_watch u_bw (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .assigned (flag_assigned[t]),
      .update   (flag_update),
      .consume  (bw_consume[t]),
      .hit      (bw_hit[t]),
      .pending  (bw_pend[t])
    );
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    ctl_nxt = ctl_r;
    for (int t = 0; t < NTHR; t++)
    begin
      ctl_nxt.out[t].force_ie  = 1'b0;
      ctl_nxt.out[t].priv_trap = 1'b0;
      ctl_nxt.out[t].resume    = 1'b0;
      ctl_nxt.out[t].take_trap = 1'b0;
      ctl_nxt.out[t].cause     = WAKE_NONE;
      tmr_start[t]  = 1'b0;
      bw_consume[t] = 1'b0;
      tmr_run[t]    = (ctl_r.st[t] == ASLEEP);
      do_susp[t]  = 1'b0;
      do_sleep[t] = 1'b0;
      if (ctl_r.st[t] == RUN && issue[t].valid)
      begin
        do_susp[t]  = is_op(issue[t].insn, OPF_SUSPEND); // [RQ1]
        do_sleep[t] = is_op(issue[t].insn, OPF_SLEEP); // [RQ4]
      end
    end

    for (int t = 0; t < NTHR; t++)
    begin
      unique case (ctl_r.st[t])
        RUN:
        begin
          if (evt[t].sys_reset)
            ctl_nxt.st[t] = RUN;
          else if (do_susp[t])
          begin
            if (!issue[t].priv)
              ctl_nxt.out[t].priv_trap = 1'b1; // [RQ12]
            else
            begin
              ctl_nxt.st[t]             = HALTED; // [RQ1]
              ctl_nxt.out[t].force_ie   = 1'b1; // [RQ2]
            end
          end
          else if (do_sleep[t])
          begin
            // Sleep raises no exception in any mode [RQ12]
            if (bw_pend[t] || bw_hit[t])
            begin
              // Remembered flag update: sleep completes without sleeping [RQ10]
              bw_consume[t]          = 1'b1;
              ctl_nxt.out[t].resume  = 1'b1;
              ctl_nxt.out[t].cause   = WAKE_FLAG;
            end
            else
            begin
              ctl_nxt.st[t]          = ASLEEP; // [RQ4]
              ctl_nxt.ie_at_sleep[t] = issue[t].global_interrupt_enable; // [RQ9]
              tmr_start[t]           = 1'b1;
              bw_consume[t]          = 1'b1;
            end
          end
        end
        HALTED:
        begin
          // Only reset or interrupt traps release a halted thread [RQ3]
          if (evt[t].sys_reset)
            ctl_nxt.st[t] = RUN;
          else if (evt[t].vec_intr || evt[t].lvl_intr)
          begin
            ctl_nxt.st[t]            = RUN; // [RQ3]
            ctl_nxt.out[t].take_trap = 1'b1;
            ctl_nxt.out[t].cause     = WAKE_INTR;
          end
        end
        ASLEEP:
        begin
          if (evt[t].sys_reset)
            ctl_nxt.st[t] = RUN; // [RQ5]
          else if ((evt[t].vec_intr && ctl_r.ie_at_sleep[t]) || evt[t].lvl_intr)
          begin
            // Vectored interrupt ignored if enable was clear at entry [RQ9]
            ctl_nxt.st[t]            = RUN; // [RQ5]
            ctl_nxt.out[t].take_trap = 1'b1; // [RQ13]
            ctl_nxt.out[t].cause     = WAKE_INTR;
          end
          else if (tmr_exp[t] || bw_hit[t])
          begin
            ctl_nxt.st[t]          = RUN;
            bw_consume[t]          = bw_hit[t];
            ctl_nxt.out[t].resume  = 1'b1; // [RQ13]
            ctl_nxt.out[t].cause   = tmr_exp[t] ? WAKE_TIMEOUT : WAKE_FLAG; // [RQ6] [RQ8]
          end
        end
        default:
          ctl_nxt.st[t] = RUN;
      endcase
    end

    // Sibling swap: the sleeper yields to the newcomer [RQ11]
    for (int t = 0; t < NTHR; t++)
    begin
      if (do_sleep[t] && ctl_nxt.st[t] == ASLEEP && ctl_r.st[1-t] == ASLEEP
          && ctl_nxt.st[1-t] == ASLEEP)
      begin
        ctl_nxt.st[1-t]         = RUN; // [RQ11]
        ctl_nxt.out[1-t].resume = 1'b1;
        ctl_nxt.out[1-t].cause  = WAKE_SIBLING;
      end
    end

    for (int t = 0; t < NTHR; t++)
      ctl_nxt.out[t].halted = (ctl_nxt.st[t] != RUN);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctl_r <= '0;
    end
    else
      ctl_r <= ctl_nxt;
  end

  assign thr_out = ctl_r.out;
endmodule : thread_halt_ctrl
`default_nettype wire

// *** verification/halt_sva.sv ***
// Purpose: Port checks for thread_halt_ctrl, thread 0 traffic
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Issue is only taken while the thread is not halted
`default_nettype none
module halt_sva
  import halt_pkg::*;
(
  input wire logic                           sys_clk,
  input wire logic                           rstn,
  input wire issue_s   [NTHR-1:0]            issue,
  input wire thr_evt_s [NTHR-1:0]            evt,
  input wire logic     [NTHR-1:0][NFLAG-1:0] flag_assigned,
  input wire logic     [NFLAG-1:0]           flag_update,
  input wire thr_out_s [NTHR-1:0]            thr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Decode
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire thr_out_s o = thr_out[0];
  function automatic logic op(logic [31:0] i, logic [8:0] f);
    return i[OP_HI:OP_LO] == OP_FMT3 && i[OP3_HI:OP3_LO] == OP3_IMPDEP && i[OPF_HI:OPF_LO] == f;
  endfunction : op
  sequence s_susp;
    issue[0].valid && !o.halted && op(issue[0].insn, OPF_SUSPEND);
  endsequence
  sequence s_sleep;
    issue[0].valid && !o.halted && op(issue[0].insn, OPF_SLEEP);
  endsequence
  // ==========================================================================
  // Properties
  chk_susp_halt: assert property (s_susp ##0 issue[0].priv |=> o.halted && o.force_ie)
    else $error("suspend did not halt");
  chk_susp_refuse: assert property (s_susp ##0 !issue[0].priv |=> o.priv_trap && !o.halted)
    else $error("user suspend not trapped");
  chk_sleep_noexc: assert property (s_sleep |=> !o.priv_trap)
    else $error("sleep raised a trap");
  chk_lvl_wake: assert property (o.halted && evt[0].lvl_intr && !evt[0].sys_reset |=> o.take_trap && !o.halted)
    else $error("level interrupt did not wake");
  chk_reset_wake: assert property (o.halted && evt[0].sys_reset |=> !o.halted && !o.resume)
    else $error("reset did not release");
  chk_trap_cause: assert property (o.take_trap |-> o.cause == WAKE_INTR)
    else $error("trap wake cause wrong");
  chk_resume_cause: assert property (o.resume |-> !o.halted && o.cause != WAKE_INTR && o.cause != WAKE_NONE)
    else $error("resume cause wrong");
  chk_sleep_bound: assert property (s_sleep |=> ##[0:163] !o.halted)
    else $error("sleep outlived timeout");
endmodule : halt_sva
bind thread_halt_ctrl halt_sva u_sva (.sys_clk, .rstn, .issue, .evt, .flag_assigned, .flag_update, .thr_out);
`default_nettype wire

// *** verification/evt_model.sv ***
// Purpose: Interrupt, reset and busy-flag source beside the block
// Assumes: Every event is a one-cycle pulse launched at a clock edge
// Notes:   Driven by the bench through its tasks
`default_nettype none
module evt_model
  import halt_pkg::*;
(
  input  wire logic               sys_clk,
  output thr_evt_s [NTHR-1:0]     evt,
  output logic     [NFLAG-1:0]    flag_update
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  initial flag_update = '0;
  // Bit 2 vectored, bit 1 level, bit 0 reset
  task hit(input int t, input int k);
    @(posedge sys_clk);
    evt[t][k] <= 1'b1;
    @(posedge sys_clk);
    evt[t][k] <= 1'b0;
  endtask : hit
  task upd(input logic [NFLAG-1:0] m);
    @(posedge sys_clk);
    flag_update <= m;
    @(posedge sys_clk);
    flag_update <= '0;
  endtask : upd
endmodule : evt_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench for thread_halt_ctrl
// Assumes: Thread 0 owns busy flag 0 only
// Notes:   Pending flag memory is consumed before the sibling swap runs
`default_nettype none
module tb
  import halt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       sys_clk = 1'b0;
  logic                       rstn = 1'b0;
  issue_s [NTHR-1:0]          issue = '0;
  logic [NTHR-1:0][NFLAG-1:0] flag_assigned = '0;
  thr_evt_s [NTHR-1:0]        evt;
  logic [NFLAG-1:0]           flag_update;
  thr_out_s [NTHR-1:0]        thr_out;
  int                         bad_count = 0;
  int                         n_checks = 0;
  int                         k;
  localparam int H = 7, F = 6, P = 5, R = 4, T = 3;
  always #5 sys_clk = ~sys_clk;
  thread_halt_ctrl dut (.sys_clk, .rstn, .issue, .evt, .flag_assigned, .flag_update, .thr_out);
  evt_model em (.sys_clk, .evt, .flag_update);
  // ==========================================================================
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task iss(input int t, input logic [8:0] f, input logic p, input logic g);
    @(posedge sys_clk);
    issue[t] <= '{1'b1, {OP_FMT3, 5'h00, OP3_IMPDEP, 5'h00, f, 5'h00}, p, g};
    @(posedge sys_clk);
    issue[t].valid <= 1'b0;
  endtask : iss
  // Returns n+1 when the bit never shows
  task wfor(input int t, input int b, input int n, output int c);
    for (c = 0; c <= n; c++)
    begin
      #1;
      if (thr_out[t][b] === 1'b1)
        break;
      @(posedge sys_clk);
    end
  endtask : wfor
  // ==========================================================================
  // Scenarios
  task t_susp;
    iss(0, OPF_SUSPEND, 1'b0, 1'b0);
    wfor(0, P, 3, k);
    chk(k <= 3, 1'b1);
    chk(thr_out[0].halted, 1'b0);
    iss(0, OPF_SUSPEND, 1'b1, 1'b0);
    wfor(0, F, 3, k);
    chk(k <= 3, 1'b1);
    chk(thr_out[0].halted, 1'b1);
    repeat (200) @(posedge sys_clk);
    #1;
    chk(thr_out[0].halted, 1'b1);
    em.hit(0, 1);
    wfor(0, T, 3, k);
    chk(thr_out[0].cause, WAKE_INTR);
    chk(thr_out[0].halted, 1'b0);
  endtask : t_susp
  task t_sleep;
    iss(0, OPF_SLEEP, 1'b0, 1'b1);
    #1;
    chk(thr_out[0].halted, 1'b1);
    chk(thr_out[0].priv_trap, 1'b0);
    wfor(0, R, 170, k);
    chk(k >= 160 && k <= 162, 1'b1);
    chk(thr_out[0].cause, WAKE_TIMEOUT);
  endtask : t_sleep
  task t_vec;
    iss(0, OPF_SLEEP, 1'b1, 1'b0);
    em.hit(0, 2);
    wfor(0, T, 4, k);
    chk(k, 5);
    chk(thr_out[0].halted, 1'b1);
    em.hit(0, 0);
    #1;
    chk(thr_out[0].halted, 1'b0);
    iss(0, OPF_SLEEP, 1'b1, 1'b1);
    em.hit(0, 2);
    wfor(0, T, 3, k);
    chk(k <= 3, 1'b1);
    chk(thr_out[0].cause, WAKE_INTR);
  endtask : t_vec
  task t_pend;
    em.upd(8'h01);
    iss(0, OPF_SLEEP, 1'b1, 1'b1);
    wfor(0, R, 3, k);
    chk(k <= 3, 1'b1);
    chk(thr_out[0].cause, WAKE_FLAG);
  endtask : t_pend
  task t_sib;
    iss(1, OPF_SLEEP, 1'b1, 1'b1);
    iss(0, OPF_SLEEP, 1'b1, 1'b1);
    wfor(1, R, 3, k);
    chk(thr_out[1].cause, WAKE_SIBLING);
    chk(thr_out[0].halted, 1'b1);
    wfor(0, R, 170, k);
    chk(thr_out[0].cause, WAKE_TIMEOUT);
  endtask : t_sib
  task t_flag;
    iss(0, OPF_SLEEP, 1'b1, 1'b1);
    em.upd(8'h02);
    wfor(0, R, 4, k);
    chk(k, 5);
    em.upd(8'h01);
    wfor(0, R, 4, k);
    chk(thr_out[0].cause, WAKE_FLAG);
  endtask : t_flag
  // ==========================================================================
  // Sequence and verdict
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    flag_assigned[0] <= 8'h01;
    t_susp;
    t_sleep;
    t_vec;
    t_pend;
    t_sib;
    t_flag;
    end_of_test;
  end
  initial
  begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
